// [rtl/mms_device.sv]
// Device end: frame parser and 32-word register file
`timescale 1ns/100ps
`include "mms_params.svh"
module mms_device
	import mms_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Address straps
	input wire logic [4:0] bus_address_straps,
	// Bus
	mms_if.device bus,
	// Local view
	output logic [4:0] bus_address,
	output logic wr_pulse,
	output logic [4:0] wr_reg,
	output mms_word_t wr_data
);
	//////////////////////////////////////////////////////////////////////
	logic [2:0] mdc_sync;
	logic [1:0] dio_sync;
	logic [4:0] strap_q;
	mms_word_t regs [`MMS_NREGS];
	mms_state_e state;
	logic [5:0] cnt;
	logic [13:0] hdr;
	mms_word_t shreg;
	logic drv_o;
	logic drv_oe;
	// Clock is sampled, not used as clock, so a stopped MDC is harmless [RULE1]
	always_ff @(posedge clock) begin
		mdc_sync <= {mdc_sync[1:0], bus.mdc};
		dio_sync <= {dio_sync[0], bus.mdio_i};
	end
	wire rise = mdc_sync[1] & ~mdc_sync[2]; // [RULE2]
	wire fall = ~mdc_sync[1] & mdc_sync[2];
	wire din = dio_sync[1];
	wire [13:0] hdr_full = {hdr[12:0], din};
	// At the first turnaround rise the shifter holds start one, op, addresses, turnaround
	wire is_read = hdr_full[12:11] == `MMS_OP_READ;
	wire is_write = hdr_full[12:11] == `MMS_OP_WRITE;
	wire match = hdr_full[10:6] == bus_address; // [RULE4]
	wire [4:0] reg_sel = hdr_full[5:1]; // [RULE8]
	wire hdr_done = rise && state == MMS_HDR && cnt == 6'd13;
	wire rd_go = hdr_done && is_read && match;
	//////////////////////////////////////////////////////////////////////
	// Straps follow pins throughout reset, frozen on release [RULE5]
	always_ff @(posedge clock) begin
		if (srst) begin
			strap_q <= bus_address_straps;
		end
	end
	assign bus_address = strap_q;
	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= MMS_IDLE;
			cnt <= 6'h00;
			hdr <= 14'h0000;
		end else if (rise) begin
			case (state)
				MMS_IDLE: begin
					// Low data sampled at a rise in idle is taken as the start zero [RULE9]
					if (!din) begin
						state <= MMS_HDR;
						cnt <= 6'h00;
					end
				end
				MMS_HDR: begin
					hdr <= hdr_full;
					cnt <= cnt + 6'h01;
					if (cnt == 6'h00 && !din) begin
						state <= MMS_IDLE;
					end else if (cnt == 6'd13) begin
						// Unmatched or unknown opcode just sits out the frame [RULE13]
						state <= MMS_TURN;
						cnt <= 6'h00;
					end
				end
				MMS_TURN: begin
					// Only the second turnaround bit is spent here
					state <= MMS_DATA;
					cnt <= 6'h00;
				end
				MMS_DATA: begin
					cnt <= cnt + 6'h01;
					if (cnt == 6'd15) begin
						state <= MMS_IDLE; // [RULE14]
					end
				end
				default: state <= MMS_IDLE;
			endcase
		end
	end
	//////////////////////////////////////////////////////////////////////
	wire op_rd = hdr[12:11] == `MMS_OP_READ;
	wire op_wr = hdr[12:11] == `MMS_OP_WRITE;
	wire hit = hdr[10:6] == bus_address;
	wire [4:0] cur_reg = hdr[5:1];
	wire wr_done = rise && state == MMS_DATA && cnt == 6'd15 && op_wr && hit;
	always_ff @(posedge clock) begin
		if (srst) begin
			shreg <= `MMS_REG_RESET;
			wr_pulse <= 1'b0;
			wr_reg <= 5'h00;
			wr_data <= `MMS_REG_RESET;
		end else begin
			wr_pulse <= wr_done;
			if (rd_go) begin
				shreg <= regs[reg_sel];
			end else if (rise && state == MMS_DATA) begin
				shreg <= {shreg[14:0], din};
			end
			if (wr_done) begin
				wr_reg <= cur_reg;
				wr_data <= {shreg[14:0], din};
			end
		end
	end
	// Register file, written only by matching write frames [RULE8] [RULE12]
	genvar gi;
	generate
		for (gi = 0; gi < `MMS_NREGS; gi++) begin : g_reg
			always_ff @(posedge clock) begin
				if (srst) begin
					regs[gi] <= `MMS_REG_RESET;
				end else if (wr_done && cur_reg == 5'(gi)) begin
					regs[gi] <= {shreg[14:0], din};
				end
			end
		end
	endgenerate
	//////////////////////////////////////////////////////////////////////
	// Drive changes on MDC fall so station samples settled data at the close of the bit cell
	wire in_rd = op_rd && hit;
	wire drive_ta = state == MMS_TURN;
	wire drive_dt = state == MMS_DATA;
	always_ff @(posedge clock) begin
		if (srst) begin
			drv_oe <= 1'b0;
			drv_o <= 1'b1;
		end else if (fall) begin
			// Released in first turnaround, zero in second, then data [RULE11] [RULE3]
			drv_oe <= in_rd && (drive_ta || drive_dt);
			drv_o <= drive_ta ? 1'b0 : shreg[15];
		end else if (state == MMS_IDLE) begin
			drv_oe <= 1'b0; // [RULE14]
		end
	end
	assign bus.mdio_dev_oe = drv_oe;
	assign bus.mdio_dev_o = drv_o;
endmodule : mms_device

// [common/mms_params.svh]
// Timing counts and frame field constants for the management serial port
// Summary of operation
// [RULE1] Station clock at most 25 MHz, may stop
// [RULE2] Both sides sample data on rising clock; station samples read data at its falling tick instead
// [RULE3] Nobody drives line during idle or first read turnaround bit
// [RULE4] Device compares 5-bit device address field
// [RULE5] Address latched from straps during reset
// [RULE6] No transaction in first cycle after reset
// [RULE7] Bus idle one clock after reset release
// [RULE8] Register address selects one of 32 words
// [RULE9] Frame starts with zero then one
// [RULE10] Fixed field order: start, op, addresses, turnaround, data
// [RULE11] Read: first turnaround released, device drives zero
// [RULE12] Write: station drives one-zero, device stays off
// [RULE13] Mismatched address: no drive, no change
// [RULE14] Release line after last read bit
`ifndef MMS_PARAMS_SVH
`define MMS_PARAMS_SVH
`define MMS_CLK_NS 100
`define MMS_MDC_HALF_NS 400
`define MMS_MDC_HALF_CYC ((`MMS_MDC_HALF_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
`define MMS_OP_READ 2'h2
`define MMS_OP_WRITE 2'h1
`define MMS_TA_WRITE 2'h2
`define MMS_HDR_BITS 6'h0e
`define MMS_FRAME_BITS 6'h20
`define MMS_PRE_BITS 6'h20
`define MMS_NREGS 32
`define MMS_REG_RESET 16'h0000
`endif

// [common/mms_pkg.sv]
// Types shared by both ends of the management serial port
package mms_pkg;
	typedef enum logic [3:0] {
		MMS_IDLE = 4'h1,
		MMS_HDR = 4'h2,
		MMS_TURN = 4'h4,
		MMS_DATA = 4'h8
	} mms_state_e;
	typedef logic [15:0] mms_word_t;
endpackage : mms_pkg

// [common/mms_if.sv]
// Two-wire management bus joining station and device
`timescale 1ns/100ps
interface mms_if;
	logic mdc;
	logic mdio_sta_o;
	logic mdio_sta_oe;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	logic mdio_i;
	modport device (input mdc, input mdio_i, output mdio_dev_o, output mdio_dev_oe);
	modport station (output mdc, input mdio_i, output mdio_sta_o, output mdio_sta_oe);
endinterface : mms_if

// [rtl/mms_station.sv]
// Station end: makes MDC, sends frames, returns read data
`timescale 1ns/100ps
`include "mms_params.svh"
module mms_station
	import mms_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bus
	mms_if.station bus,
	// Request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [4:0] req_dev,
	input wire logic [4:0] req_reg,
	input wire logic [15:0] req_data,
	output logic req_ready,
	// Answer
	output logic rsp_valid,
	output logic [15:0] rsp_data
);
	//////////////////////////////////////////////////////////////////////
	logic [1:0] dio_sync;
	logic [2:0] div;
	logic mdc_q;
	logic busy;
	logic [6:0] bitn;
	logic [63:0] frame;
	logic wr_q;
	logic sta_o;
	logic sta_oe;
	logic [15:0] rd_sh;
	logic gap;
	always_ff @(posedge clock) begin
		dio_sync <= {dio_sync[0], bus.mdio_i};
	end
	// Divider gives MDC well under 25 MHz [RULE1]
	wire half = div == 3'(`MMS_MDC_HALF_CYC - 1);
	wire to_fall = half && mdc_q;
	wire to_rise = half && !mdc_q;
	// Total bits: preamble, header, turnaround, data
	wire [6:0] last_bit = 7'(`MMS_PRE_BITS + `MMS_FRAME_BITS - 1);
	wire [6:0] ta_bit = 7'(`MMS_PRE_BITS + `MMS_HDR_BITS);
	always_ff @(posedge clock) begin
		if (srst) begin
			div <= 3'h0;
			mdc_q <= 1'b0;
		end else begin
			div <= half ? 3'h0 : div + 3'h1;
			if (half) begin
				mdc_q <= !mdc_q;
			end
		end
	end
	//////////////////////////////////////////////////////////////////////
	// Gap flag keeps the bus quiet until the first MDC rise, half an MDC cycle after reset [RULE6] [RULE7]
	always_ff @(posedge clock) begin
		if (srst) begin
			busy <= 1'b0;
			gap <= 1'b1;
			bitn <= 7'h00;
			frame <= 64'h0;
			wr_q <= 1'b0;
			sta_o <= 1'b1;
			sta_oe <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rd_sh <= 16'h0000;
		end else begin
			rsp_valid <= 1'b0;
			if (to_rise && gap) begin
				gap <= 1'b0;
			end
			req_ready <= !busy && !gap && !req_valid;
			if (!busy && !gap && req_valid && to_fall) begin
				busy <= 1'b1;
				bitn <= 7'h00;
				wr_q <= req_write;
				// Preamble ones, start, opcode, addresses, turnaround, data [RULE9] [RULE10]
				// Write turnaround is sent as one then zero [RULE12]
				frame <= {32'hffffffff, 2'h1,
					req_write ? `MMS_OP_WRITE : `MMS_OP_READ,
					req_dev, req_reg, `MMS_TA_WRITE, req_data};
				sta_oe <= 1'b1;
				sta_o <= 1'b1;
			end else if (busy && to_fall) begin
				frame <= {frame[62:0], 1'b1};
				sta_o <= frame[62];
				// Read: release from first turnaround bit onward [RULE11] [RULE3]
				sta_oe <= bitn != last_bit && (wr_q || bitn + 7'h01 < ta_bit);
				bitn <= bitn + 7'h01;
				if (bitn == last_bit) begin
					busy <= 1'b0;
					sta_oe <= 1'b0;
					if (!wr_q) begin
						rsp_valid <= 1'b1;
						rsp_data <= {rd_sh[14:0], dio_sync[1]};
					end
				end
			end
			// Sample at the close of each bit cell: the device answers through its
			// own synchroniser, so its data settles three clocks after our falling edge [RULE2]
			if (busy && to_fall && bitn > ta_bit) begin
				rd_sh <= {rd_sh[14:0], dio_sync[1]};
			end
		end
	end
	assign bus.mdc = mdc_q;
	assign bus.mdio_sta_o = sta_o;
	assign bus.mdio_sta_oe = sta_oe;
endmodule : mms_station

// [sim/mms_props.sv]
// Wire checker for the management serial bus
`timescale 1ns/100ps
module mms_props (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bus wires
	input wire logic mdc,
	input wire logic mdio_sta_o,
	input wire logic mdio_sta_oe,
	input wire logic mdio_dev_o,
	input wire logic mdio_dev_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Drive span counter; 17 bits of 8 clocks expected
	logic [7:0] oe_cnt;
	always_ff @(posedge clock) begin
		oe_cnt <= mdio_dev_oe ? oe_cnt + 8'h01 : 8'h00;
	end
	sequence s_take;
		$rose(mdio_dev_oe);
	endsequence
	sequence s_drop;
		$fell(mdio_dev_oe);
	endsequence
	////////////////////////////////////////////////////////////////
	AST_NO_FIGHT: assert property (!(mdio_sta_oe && mdio_dev_oe))
		else $error("both ends drive");
	AST_RST_QUIET: assert property ($fell(srst) |-> !mdio_sta_oe[*4])
		else $error("station drives after reset");
	AST_MDC_HALF: assert property ($rose(mdc) |-> mdc[*4] ##1 !mdc)
		else $error("clock half period");
	AST_STA_STEADY: assert property (mdc && $past(mdc) && mdio_sta_oe |-> $stable(mdio_sta_o))
		else $error("station data moves while clock high");
	AST_DEV_STEADY: assert property (mdc && $past(mdc) && mdio_dev_oe |-> $stable(mdio_dev_o))
		else $error("device data moves while clock high");
	AST_TA_ZERO: assert property (s_take |-> !mdio_dev_o)
		else $error("second turnaround bit not zero");
	AST_TA_FREE: assert property (s_take |-> $past(mdio_sta_oe, 6) == 1'b0)
		else $error("first turnaround bit driven");
	AST_DEV_SPAN: assert property (s_drop |-> $past(oe_cnt) inside {[8'd130:8'd140]})
		else $error("device drive span");
	AST_DEV_RELEASE: assert property (s_drop |-> !mdio_dev_oe[*8])
		else $error("device drives again");
endmodule : mms_props

// [sim/test_mdio_management_slave.sv]
// Self-checking bench joining station and device ends
`timescale 1ns/100ps
module test_mdio_management_slave;
	import mms_pkg::*;
	logic clock, srst, req_valid, req_write, req_ready, rsp_valid, wr_pulse;
	logic [4:0] straps, dev_addr, bus_address, req_dev, req_reg, wr_reg;
	mms_word_t req_data, rsp_data, wr_data;
	mms_word_t regs [32];
	mms_word_t rq [$];
	logic [20:0] wq [$];
	int error_cnt, tests_run, cyc, seed;
	mms_if bus_if ();
	// Pull-up wire: any driver may pull low
	assign bus_if.mdio_i = (~bus_if.mdio_sta_oe | bus_if.mdio_sta_o)
		& (~bus_if.mdio_dev_oe | bus_if.mdio_dev_o);
	mms_station mms_station_inst (.clock(clock), .srst(srst), .bus(bus_if.station),
		.req_valid(req_valid), .req_write(req_write), .req_dev(req_dev), .req_reg(req_reg),
		.req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
	mms_device mms_device_inst (.clock(clock), .srst(srst), .bus_address_straps(straps),
		.bus(bus_if.device), .bus_address(bus_address), .wr_pulse(wr_pulse), .wr_reg(wr_reg),
		.wr_data(wr_data));
	mms_props mms_props_inst (.clock(clock), .srst(srst), .mdc(bus_if.mdc),
		.mdio_sta_o(bus_if.mdio_sta_o), .mdio_sta_oe(bus_if.mdio_sta_oe),
		.mdio_dev_o(bus_if.mdio_dev_o), .mdio_dev_oe(bus_if.mdio_dev_oe));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [20:0] seen, input logic [20:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task stop_test();
		$display("errors %0d in %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Holds the request over two falling ticks so it is surely taken
	task automatic do_req(input logic w, input logic [4:0] d, input logic [4:0] r);
		mms_word_t v;
		v = $random(seed);
		do @(negedge clock); while (req_ready !== 1'b1);
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= w;
		req_dev <= d;
		req_reg <= r;
		req_data <= v;
		if (w && d == dev_addr) begin
			regs[r] = v;
			wq.push_back({r, v});
		end else if (!w) begin
			rq.push_back(d == dev_addr ? regs[r] : 16'hffff);
		end
		repeat (20) @(posedge clock);
		req_valid <= 1'b0;
	endtask : do_req
	////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			stop_test();
		end
	end
	always @(negedge clock) begin
		if (rsp_valid === 1'b1)
			check({5'h0, rsp_data}, rq.size() ? {5'h0, rq.pop_front()} : 21'h1fffff);
		if (wr_pulse === 1'b1)
			check({wr_reg, wr_data}, wq.size() ? wq.pop_front() : 'x);
	end
	initial begin
		seed = 32'h52e2;
		srst = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_dev = 5'h00;
		req_reg = 5'h00;
		req_data = 16'h0000;
		straps = $random(seed);
		dev_addr = straps;
		foreach (regs[i]) regs[i] = 16'h0000;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		straps <= ~straps;
		repeat (3) @(posedge clock);
		@(negedge clock);
		check({16'h0, bus_address}, {16'h0, dev_addr});
		do_req(1'b0, dev_addr, 5'h00);
		do_req(1'b1, dev_addr ^ 5'h01, 5'h1f);
		do_req(1'b0, dev_addr ^ 5'h10, 5'h1f);
		for (int i = 0; i < 16; i++) begin
			do_req(~i[0], dev_addr, {2'h3, i[3:1]});
		end
		do_req(1'b0, dev_addr, 5'h1f);
		do @(negedge clock); while (req_ready !== 1'b1);
		repeat (50) @(posedge clock);
		check(21'(rq.size() + wq.size()), 21'h0);
		stop_test();
	end
endmodule : test_mdio_management_slave
